// ---- hw/adcsq_sequencer.sv ----
// Module: control and sequencing of a 10-bit successive-approximation converter.
//
// Notes on behaviour
// - A conversion lasts exactly twelve bit periods from the go bit being set.
// - Clock select codes give 2,4,8,16,32,64 clocks per bit; 011 picks RC.
// - Clearing go during a conversion aborts it at once.
// - An aborted conversion leaves the result pair untouched.
// - After an abort wait two bit periods, then acquisition restarts.
// - Result is stored left or right justified with unused bits zero.
// - With the converter off the result registers are plain read/write storage.
// - Port reads return zero on pins configured as analog inputs.
// - The selected pin is sampled whatever its direction.
// - Channel and direction bits never gate starting or running a conversion.
// - With RC selected the bit period comes from the RC oscillator tick.
// - Completion loads the result, clears go and sets the done flag together.
// - Justify 1 zeroes the high six bits of high; 0 zeroes low six of low.
// - Two bit periods pass after completion before acquisition resumes.
// - Reset returns control registers to reset values and aborts conversions.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

module adcsq_sequencer
  import adcsq_pkg::*;
#(
  parameter int PINS = 8
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Interrupt
  output logic irq_out,
  // Analog side
  input wire logic rc_osc_in,
  input wire logic comp_above_in,
  input wire logic [PINS-1:0] port_pins_in,
  output logic sampling_out,
  output logic [2:0] channel_sel_out,
  output logic [7:0] dac_trial_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clock periods per bit period for each oscillator code, minus one.
  function automatic logic [5:0] tad_div(input logic [2:0] sel);
    case (sel)
      3'h0: tad_div = 6'h01;
      3'h4: tad_div = 6'h03;
      3'h1: tad_div = 6'h07;
      3'h5: tad_div = 6'h0F;
      3'h2: tad_div = 6'h1F;
      3'h6: tad_div = 6'h3F;
      default: tad_div = 6'h01;
    endcase
  endfunction

  // One bit per pin, set where the port configuration makes it analog.
  function automatic logic [7:0] analog_map(input logic [3:0] cfg);
    case (cfg)
      4'h0, 4'h1, 4'h8: analog_map = 8'hFF;
      4'h2, 4'h3, 4'hC: analog_map = 8'h1F;
      4'h4, 4'h5, 4'hD: analog_map = 8'h0B;
      4'h9, 4'hA, 4'hB: analog_map = 8'h3F;
      4'hE, 4'hF: analog_map = 8'h01;
      default: analog_map = 8'h00;
    endcase
  endfunction

  // Trial word: decided bits plus the bit under test, top eight bits only.
  // The comparator sees eight bits, so the trials of the two lowest bits are implied.
  function automatic logic [7:0] trial_word(input logic [9:0] sar, input logic [3:0] idx);
    logic [9:0] probe;
    probe = sar | (10'h001 << idx);
    trial_word = probe[9:2];
  endfunction

  // Places the result in the 16-bit pair; positions it does not fill are zero.
  function automatic logic [15:0] justify_pair(input logic [9:0] r, input logic to_right);
    if (to_right)
    begin
      justify_pair = {6'h00, r};
    end
    else
    begin
      justify_pair = {r, 6'h00};
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  adcsq_state_vec_t s_q;
  adcsq_state_vec_t s_d;
  adcsq_bus_req_t req;
  logic [2:0] clk_sel;
  logic tad_tick;
  logic on;
  logic go_wr_set;
  logic go_wr_clr;
  logic wr_main;
  logic [9:0] result;
  logic [7:0] port_view;
  logic [7:0] pins_ext;
  logic [7:0] analog;

  always_comb
  begin
    req.addr = reg_addr_in;
    req.wdata = reg_wdata_in;
    req.wr = reg_wr_in;
    req.rd = reg_rd_in;
  end

  assign clk_sel = {s_q.ctrl_fmt[6], s_q.ctrl_main[7:6]};
  assign on = s_q.ctrl_main[ADCSQ_MAIN_ON_BIT];
  assign wr_main = req.wr && (req.addr == ADCSQ_OFS_CTRL_MAIN);
  assign go_wr_set = wr_main && req.wdata[ADCSQ_MAIN_GO_BIT];
  assign go_wr_clr = wr_main && !req.wdata[ADCSQ_MAIN_GO_BIT];
  assign pins_ext = 8'(port_pins_in);
  assign analog = analog_map(s_q.ctrl_fmt[3:0]);
  assign result = s_q.sar;

  // Port read view; an analog pin reads low whatever level it carries.
  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_port
      assign port_view[g] = pins_ext[g] && !analog[g];
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rc_sync1 = rc_osc_in;
    s_d.rc_sync2 = s_q.rc_sync1;
    s_d.rc_prev = s_q.rc_sync2;
    s_d.chan = s_q.ctrl_main[5:3];

    // ----------------------------------------
    // Bit period tick from the oscillator divider or the RC source.
    // ----------------------------------------
    tad_tick = 1'b0;
    if (clk_sel == ADCSQ_CLK_SEL_RC)
    begin
      tad_tick = s_q.rc_sync2 && !s_q.rc_prev;
      s_d.div_cnt = 6'h00;
    end
    else if (s_q.div_cnt >= tad_div(clk_sel))
    begin
      tad_tick = 1'b1;
      s_d.div_cnt = 6'h00;
    end
    else
    begin
      s_d.div_cnt = s_q.div_cnt + 6'h01;
    end

    // ----------------------------------------
    // Register writes.
    // ----------------------------------------
    if (req.wr)
    begin
      case (req.addr)
        ADCSQ_OFS_CTRL_MAIN:
        begin
          // The go bit is owned by the sequencer below, never by a plain write.
          s_d.ctrl_main = (req.wdata & ADCSQ_MAIN_WMASK & ~8'h04) |
                          (s_q.ctrl_main & 8'h04);
        end
        ADCSQ_OFS_CTRL_FMT:
        begin
          s_d.ctrl_fmt = req.wdata & ADCSQ_FMT_WMASK;
        end
        ADCSQ_OFS_RES_HIGH:
        begin
          s_d.res_high = req.wdata;
        end
        ADCSQ_OFS_RES_LOW:
        begin
          s_d.res_low = req.wdata;
        end
        ADCSQ_OFS_IRQ_STAT:
        begin
          s_d.irq_stat = s_q.irq_stat & ~req.wdata[1:0];
        end
        ADCSQ_OFS_IRQ_MASK:
        begin
          s_d.irq_mask = req.wdata[1:0];
        end
        default:
        begin
          s_d.irq_mask = s_q.irq_mask;
        end
      endcase
    end

    // ----------------------------------------
    // Sequencer; depends on enable, go and the bit period tick, never on channel or pin direction.
    // ----------------------------------------
    case (s_q.state)
      ADCSQ_IDLE:
      begin
        s_d.sampling = on;
        // A start written together with the enable is not taken.
        if (go_wr_set && on)
        begin
          s_d.ctrl_main[ADCSQ_MAIN_GO_BIT] = 1'b1;
          s_d.state = ADCSQ_CONVERT;
          s_d.tad_cnt = 4'h0;
          s_d.bit_idx = ADCSQ_RESULT_BITS - 4'h1;
          s_d.sar = 10'h000;
          s_d.sampling = 1'b0;
          s_d.div_cnt = 6'h00;
        end
      end
      ADCSQ_CONVERT:
      begin
        if (!on || go_wr_clr)
        begin
          // Abort: result pair is left alone.
          s_d.ctrl_main[ADCSQ_MAIN_GO_BIT] = 1'b0;
          s_d.irq_stat[ADCSQ_IRQ_ABORT_BIT] = 1'b1;
          s_d.div_cnt = 6'h00;
          s_d.state = ADCSQ_WAIT;
          s_d.tad_cnt = 4'h0;
        end
        else if (tad_tick)
        begin
          s_d.tad_cnt = s_q.tad_cnt + 4'h1;
          // Bit periods 1..10 resolve one bit each, MSB first.
          if (s_q.tad_cnt >= 4'h1 && s_q.tad_cnt <= ADCSQ_RESULT_BITS)
          begin
            s_d.sar[s_q.bit_idx] = comp_above_in;
            s_d.bit_idx = s_q.bit_idx - 4'h1;
          end
          if (s_q.tad_cnt == ADCSQ_CONV_TADS - 4'h1)
          begin
            // Result, go clear and done flag land in one update.
            {s_d.res_high, s_d.res_low} =
              justify_pair(result, s_q.ctrl_fmt[ADCSQ_FMT_JUSTIFY_BIT]);
            s_d.ctrl_main[ADCSQ_MAIN_GO_BIT] = 1'b0;
            s_d.irq_stat[ADCSQ_IRQ_DONE_BIT] = 1'b1;
            s_d.state = ADCSQ_WAIT;
            s_d.tad_cnt = 4'h0;
          end
        end
      end
      ADCSQ_WAIT:
      begin
        s_d.sampling = 1'b0;
        if (tad_tick)
        begin
          s_d.tad_cnt = s_q.tad_cnt + 4'h1;
        end
        // Acquisition resumes only after two full bit periods.
        if (tad_tick && s_q.tad_cnt == ADCSQ_WAIT_TADS - 4'h1)
        begin
          s_d.state = ADCSQ_IDLE;
          s_d.sampling = on;
        end
      end
      default: s_d.state = ADCSQ_IDLE;
    endcase

    // ----------------------------------------
    // Comparator trial word and interrupt level.
    // ----------------------------------------
    s_d.trial = 8'h00;
    if (s_d.state == ADCSQ_CONVERT)
    begin
      s_d.trial = trial_word(s_d.sar, s_d.bit_idx);
    end
    // Hardware set wins over a software clear in the same cycle.
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // ----------------------------------------
    // Read data, standing one cycle after the strobe.
    // ----------------------------------------
    s_d.rdata = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        ADCSQ_OFS_RES_HIGH:
        begin
          s_d.rdata = s_q.res_high;
        end
        ADCSQ_OFS_RES_LOW:
        begin
          s_d.rdata = s_q.res_low;
        end
        ADCSQ_OFS_CTRL_MAIN:
        begin
          s_d.rdata = s_q.ctrl_main;
        end
        ADCSQ_OFS_CTRL_FMT:
        begin
          s_d.rdata = s_q.ctrl_fmt;
        end
        ADCSQ_OFS_IRQ_STAT:
        begin
          s_d.rdata = {6'h00, s_q.irq_stat};
        end
        ADCSQ_OFS_IRQ_MASK:
        begin
          s_d.rdata = {6'h00, s_q.irq_mask};
        end
        ADCSQ_OFS_PORT:
        begin
          s_d.rdata = port_view;
        end
        default:
        begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Result registers reset to zero here; software must not rely on it.
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_q <= '0;
      s_q.state <= ADCSQ_IDLE;
      s_q.ctrl_main <= ADCSQ_MAIN_RESET;
      s_q.ctrl_fmt <= ADCSQ_FMT_RESET;
      s_q.irq_stat <= ADCSQ_IRQ_RESET;
      s_q.irq_mask <= ADCSQ_IRQ_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign irq_out = s_q.irq;
  assign sampling_out = s_q.sampling;
  assign channel_sel_out = s_q.chan;
  assign dac_trial_out = s_q.trial;

endmodule

// ---- hw/adcsq_pkg.sv ----
// Package: register map, field layout, reset values and timing constants of the conversion sequencer.
package adcsq_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [2:0] ADCSQ_OFS_RES_HIGH = 3'h0;
  localparam logic [2:0] ADCSQ_OFS_RES_LOW = 3'h1;
  localparam logic [2:0] ADCSQ_OFS_CTRL_MAIN = 3'h2;
  localparam logic [2:0] ADCSQ_OFS_CTRL_FMT = 3'h3;
  localparam logic [2:0] ADCSQ_OFS_IRQ_STAT = 3'h4;
  localparam logic [2:0] ADCSQ_OFS_IRQ_MASK = 3'h5;
  localparam logic [2:0] ADCSQ_OFS_PORT = 3'h6;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int ADCSQ_MAIN_ON_BIT = 0;
  localparam int ADCSQ_MAIN_GO_BIT = 2;
  localparam int ADCSQ_FMT_JUSTIFY_BIT = 7;
  localparam logic [7:0] ADCSQ_MAIN_RESET = 8'h00;
  localparam logic [7:0] ADCSQ_FMT_RESET = 8'h00;
  localparam logic [7:0] ADCSQ_MAIN_WMASK = 8'hFD;
  localparam logic [7:0] ADCSQ_FMT_WMASK = 8'hCF;
  localparam logic [1:0] ADCSQ_IRQ_RESET = 2'h0;
  localparam int ADCSQ_IRQ_DONE_BIT = 0;
  localparam int ADCSQ_IRQ_ABORT_BIT = 1;

  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  localparam logic [3:0] ADCSQ_CONV_TADS = 4'hC;
  localparam logic [3:0] ADCSQ_WAIT_TADS = 4'h2;
  localparam logic [3:0] ADCSQ_RESULT_BITS = 4'hA;
  localparam logic [2:0] ADCSQ_CLK_SEL_RC = 3'h3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    ADCSQ_IDLE = 3'b001,
    ADCSQ_CONVERT = 3'b010,
    ADCSQ_WAIT = 3'b100
  } adcsq_state_t;

  typedef struct packed
  {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcsq_bus_req_t;

  typedef struct packed
  {
    adcsq_state_t state;
    logic [7:0] ctrl_main;
    logic [7:0] ctrl_fmt;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [5:0] div_cnt;
    logic [3:0] tad_cnt;
    logic [3:0] bit_idx;
    logic [9:0] sar;
    logic rc_sync1;
    logic rc_sync2;
    logic rc_prev;
    logic [7:0] rdata;
    logic irq;
    logic sampling;
    logic [2:0] chan;
    logic [7:0] trial;
  } adcsq_state_vec_t;

endpackage

// ---- bench/adcsq_seq_checker.sv ----
// Checker: register port and sequencer output relations of the conversion sequencer.
`timescale 1ns/1ps
module adcsq_seq_checker
  import adcsq_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Sequencer outputs
  input wire logic irq_out,
  input wire logic sampling_out,
  input wire logic [7:0] dac_trial_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic [1:0] mask_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in)
      mask_q <= 2'h0;
    else if (reg_wr_in && reg_addr_in == ADCSQ_OFS_IRQ_MASK)
      mask_q <= reg_wdata_in[1:0];
  // Two steps, so a mask rewrite in the next cycle cannot raise a false failure.
  sequence mask_cleared_s;
    reg_wr_in && reg_addr_in == ADCSQ_OFS_IRQ_MASK && reg_wdata_in[1:0] == 2'h0
      ##1 !(reg_wr_in && reg_addr_in == ADCSQ_OFS_IRQ_MASK);
  endsequence
  sequence turned_off_s;
    reg_wr_in && reg_addr_in == ADCSQ_OFS_CTRL_MAIN && !reg_wdata_in[0]
      ##1 !(reg_wr_in && reg_addr_in == ADCSQ_OFS_CTRL_MAIN);
  endsequence
  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside an answer");
  unmapped_read_a: assert property (reg_rd_in && reg_addr_in == 3'h7 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  fmt_reserved_a: assert property (reg_rd_in && reg_addr_in == ADCSQ_OFS_CTRL_FMT
    |=> reg_rdata_out[5:4] == 2'h0)
    else $error("format reserved bits not zero");
  main_reserved_a: assert property (reg_rd_in && reg_addr_in == ADCSQ_OFS_CTRL_MAIN
    |=> !reg_rdata_out[1])
    else $error("main reserved bit not zero");
  dac_idle_a: assert property (sampling_out |-> dac_trial_out == 8'h00)
    else $error("trial word driven while acquiring");
  mask_read_a: assert property (reg_rd_in && reg_addr_in == ADCSQ_OFS_IRQ_MASK
    |=> reg_rdata_out[1:0] == mask_q)
    else $error("mask read differs from last write");
  irq_masked_a: assert property (mask_cleared_s |=> !irq_out)
    else $error("interrupt high with mask clear");
  off_idle_a: assert property (turned_off_s |=> !sampling_out)
    else $error("acquiring while converter off");
endmodule

bind adcsq_sequencer adcsq_seq_checker chk (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
  .sampling_out(sampling_out), .dac_trial_out(dac_trial_out));

// ---- bench/adcsq_analog_model.sv ----
// Model: comparator, held channel levels and RC oscillator of the analog side.
`timescale 1ns/1ps
module adcsq_analog_model
(
  // Trial word and channel from the sequencer
  input wire logic [2:0] channel_sel_out,
  input wire logic [7:0] dac_trial_out,
  // Comparator and RC clock to the sequencer
  output logic comp_above_in,
  output logic rc_osc_in
);
  // Each level ends in two ones, so the 8-bit trial view decides all ten bits.
  always_comb
    comp_above_in = {channel_sel_out, 5'h15} >= dac_trial_out;
  // The RC source runs free, unrelated to the system clock; period 280 ns.
  // Offset by 10 ns so that no RC edge meets a system clock edge.
  initial
  begin
    rc_osc_in = 1'b0;
    #10;
    forever #140 rc_osc_in = ~rc_osc_in;
  end
endmodule

// ---- bench/adcsq_sequencer_test.sv ----
// Testbench: registers, timed conversions, abort and reset of the conversion sequencer.
`timescale 1ns/1ps
module adcsq_sequencer_test
  import adcsq_pkg::*;
;
  localparam logic [2:0] A_HI = ADCSQ_OFS_RES_HIGH;
  localparam logic [2:0] A_LO = ADCSQ_OFS_RES_LOW;
  localparam logic [2:0] A_MN = ADCSQ_OFS_CTRL_MAIN;
  localparam logic [2:0] A_FM = ADCSQ_OFS_CTRL_FMT;
  localparam logic [2:0] A_ST = ADCSQ_OFS_IRQ_STAT;
  localparam logic [2:0] A_MK = ADCSQ_OFS_IRQ_MASK;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] pins = 8'hFF;
  logic [7:0] rdata;
  logic irq, smp, rc, comp;
  logic [2:0] chan;
  logic [7:0] trial;
  logic [2:0] codes [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  adcsq_sequencer #(.PINS(8)) dut (.sys_clk_in(clk), .resetn_in(resetn),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .irq_out(irq), .rc_osc_in(rc), .comp_above_in(comp),
    .port_pins_in(pins), .sampling_out(smp), .channel_sel_out(chan), .dac_trial_out(trial));
  adcsq_analog_model model (.channel_sel_out(chan), .dac_trial_out(trial),
    .comp_above_in(comp), .rc_osc_in(rc));
  task automatic fail(input string m);
    err_total++;
    $display("ERROR at %0t: %s", $time, m);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    n_checks++;
    if (rdata !== e)
      fail($sformatf("reg %0h read %h want %h", a, rdata, e));
  endtask
  task automatic chk_n(input int got, input int e);
    n_checks++;
    if (got != e)
      fail($sformatf("took %0d cycles want %0d", got, e));
  endtask
  task automatic chk_bit(input logic got, input logic e);
    n_checks++;
    if (got !== e)
      fail("interrupt level wrong");
  endtask
  // Waits out the two-period pause so the next start is never refused.
  task automatic convert(input logic [2:0] cd, input logic [2:0] ch, input logic j, input int e);
    logic [9:0] r;
    int n;
    r = {ch, 5'h15, 2'b11};
    wr(A_FM, {j, cd[2], 6'h06});
    wr(A_MN, {cd[1:0], ch, 3'b001});
    wr(A_MN, {cd[1:0], ch, 3'b101});
    n = 1;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (e > 0)
      chk_n(n, e);
    repeat (130) @(posedge clk);
    rd_chk(A_MN, {cd[1:0], ch, 3'b001});
    rd_chk(A_ST, 8'h01);
    rd_chk(A_HI, j ? {6'h00, r[9:8]} : r[9:2]);
    rd_chk(A_LO, j ? r[7:0] : {r[1:0], 6'h00});
    wr(A_ST, 8'h01);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail("timeout");
      report_and_stop();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd_chk(A_MN, ADCSQ_MAIN_RESET);
    rd_chk(A_FM, ADCSQ_FMT_RESET);
    rd_chk(3'h7, 8'h00);
    wr(A_HI, 8'hA5);
    wr(A_LO, 8'h3C);
    rd_chk(A_HI, 8'hA5);
    rd_chk(A_LO, 8'h3C);
    wr(A_MN, 8'h04);
    rd_chk(A_MN, 8'h00);
    wr(A_MN, 8'h05);
    rd_chk(A_MN, 8'h01);
    wr(A_FM, 8'h00);
    rd_chk(ADCSQ_OFS_PORT, 8'h00);
    wr(A_FM, 8'h0E);
    rd_chk(ADCSQ_OFS_PORT, 8'hFE);
    $display("test registers finished");
    wr(A_MK, 8'h01);
    rd_chk(A_MK, 8'h01);
    for (int i = 0; i < 6; i++)
      convert(codes[i], i[2:0], i[0], 12 * (2 << i) + 1);
    convert(ADCSQ_CLK_SEL_RC, 3'h7, 1'b1, 0);
    $display("test conversions finished");
    wr(A_FM, 8'h46);
    wr(A_MN, 8'h85);
    repeat (20) @(posedge clk);
    wr(A_MN, 8'h81);
    rd_chk(A_ST, 8'h02);
    wr(A_MN, 8'h85);
    rd_chk(A_MN, 8'h81);
    rd_chk(A_HI, 8'h03);
    rd_chk(A_LO, 8'hD7);
    chk_bit(irq, 1'b0);
    wr(A_MK, 8'h03);
    @(posedge clk);
    chk_bit(irq, 1'b1);
    wr(A_ST, 8'h02);
    wr(A_MK, 8'h01);
    repeat (130) @(posedge clk);
    convert(3'h0, 3'h5, 1'b0, 25);
    $display("test abort finished");
    wr(A_MK, 8'h00);
    wr(A_MN, 8'h85);
    repeat (10) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd_chk(A_MN, 8'h00);
    rd_chk(A_ST, 8'h00);
    $display("test reset finished");
    report_and_stop();
  end
endmodule
